// ### core/card_bus_lane_select.v
// Card bus lane select: host pin decode, byte steering and core access
`timescale 1ns/1ps
`include "card_bus_lane_select_consts.vh"
module card_bus_lane_select (
    input  wire        clk,
    input  wire        reset,
    input  wire [1:0]  mode,
    input  wire        ce1_n,
    input  wire        ce2_n,
    input  wire [10:0] addr,
    input  wire        oe_n,
    input  wire        we_n,
    input  wire        iord_n,
    input  wire        iowr_n,
    input  wire        dmack,
    input  wire        csel_n,
    input  wire [15:0] data_in,
    output reg  [15:0] data_out,
    output reg         data_oe_lo,
    output reg         data_oe_hi,
    output reg         wait_n,
    output reg         csel_pull_up,
    output reg         is_master,
    output wire        wr_valid,
    input  wire        wr_ready,
    output wire [2:0]  wr_space,
    output wire [10:0] wr_addr,
    output wire [1:0]  wr_be,
    output wire [15:0] wr_data,
    output reg         rd_req,
    output reg  [2:0]  rd_space,
    output reg  [10:0] rd_addr,
    output reg  [1:0]  rd_be,
    input  wire        rd_valid,
    input  wire [15:0] rd_data
);
    // ==========================================
    // States
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_WPEND = 5'h02;
    localparam [4:0] ST_RWAIT = 5'h04;
    localparam [4:0] ST_RDATA = 5'h08;
    localparam [4:0] ST_DRIVE = 5'h10;

    reg  [4:0]        state_reg;
    reg  [4:0]        state_next;
    reg               rd_act_reg;
    reg               wr_act_reg;
    reg               strap_done_reg;
    reg  [2:0]        lane_reg;
    reg  [`ENT_W-1:0] pend_reg;
    reg               rd_act;
    reg               wr_act;
    reg  [2:0]        lane;
    reg  [2:0]        space;
    reg  [10:0]       acc_addr;
    reg  [1:0]        be;
    reg  [15:0]       wdata_norm;
    reg  [15:0]       rdata_pins;
    reg               oe_lo_next;
    reg               oe_hi_next;
    wire              rd_rise;
    wire              wr_rise;
    wire              selected;
    wire              fifo_in_valid;
    wire              fifo_in_ready;
    wire              fifo_drained;
    wire [`ENT_W-1:0] fifo_out;

    // ==========================================
    // Strobe selection per mode
    always @*
    begin
        rd_act = 1'b0;
        wr_act = 1'b0;
        case (mode)
            `MODE_MEM:
            begin
                rd_act = ~oe_n;
                wr_act = ~we_n;
            end
            `MODE_IO,
            `MODE_IDE:
            begin
                rd_act = ~iord_n;
                wr_act = ~iowr_n;
            end
            default:
            begin
                rd_act = 1'b0;
                wr_act = 1'b0;
            end
        endcase
    end

    // ==========================================
    // Select and lane decode
    always @*
    begin
        lane     = `LANE_NONE;
        space    = `SPACE_MEM;
        acc_addr = 11'h000;
        if (mode == `MODE_IDE)
        begin
            if (dmack)
            begin
                if (ce1_n & ce2_n)                      // see (RQ7)
                begin
                    lane  = `LANE_WORD;                  // see (RQ15)
                    space = `SPACE_DMA;
                end
            end
            else if (~ce1_n & ce2_n)
            begin
                space    = `SPACE_TASK;                  // see (RQ5)
                acc_addr = {8'h00, addr[2:0]};           // see (RQ16)
                if (addr[2:0] == `DATA_REG_ADDR)
                    lane = `LANE_WORD;                   // see (RQ15)
                else
                    lane = `LANE_EVEN_LO;                // see (RQ14)
            end
            else if (ce1_n & ~ce2_n)
            begin
                space    = `SPACE_CTRL;                  // see (RQ6)
                acc_addr = {8'h00, addr[2:0]};           // see (RQ16)
                lane     = `LANE_EVEN_LO;                // see (RQ14)
            end
        end
        else if ((mode == `MODE_MEM) | (mode == `MODE_IO))
        begin
            space    = (mode == `MODE_IO) ? `SPACE_IO : `SPACE_MEM;
            acc_addr = addr;
            if (~ce1_n & ~ce2_n)
                lane = `LANE_WORD;                       // see (RQ1)
            else if (~ce1_n)
                lane = addr[0] ? `LANE_ODD_LO : `LANE_EVEN_LO; // see (RQ3)
            else if (~ce2_n)
                lane = `LANE_ODD_HI;                     // see (RQ2)
        end
    end

    assign selected = (lane != `LANE_NONE);              // see (RQ17)
    assign rd_rise  = rd_act & ~rd_act_reg & selected;
    assign wr_rise  = wr_act & ~wr_act_reg & selected;

    // ==========================================
    // Byte enables and write data normalisation
    always @*
    begin
        be         = `BE_NONE;
        wdata_norm = 16'h0000;
        case (lane)
            `LANE_WORD:
            begin
                be         = `BE_WORD;
                wdata_norm = data_in;                    // see (RQ12) (RQ13)
            end
            `LANE_EVEN_LO:
            begin
                be         = `BE_EVEN;
                wdata_norm = {8'h00, data_in[7:0]};      // see (RQ12)
            end
            `LANE_ODD_LO:
            begin
                be         = `BE_ODD;
                wdata_norm = {data_in[7:0], 8'h00};      // see (RQ4)
            end
            `LANE_ODD_HI:
            begin
                be         = `BE_ODD;
                wdata_norm = {data_in[15:8], 8'h00};     // see (RQ13)
            end
            default:
            begin
                be         = `BE_NONE;
                wdata_norm = 16'h0000;
            end
        endcase
    end

    // ==========================================
    // Read data steering onto pins
    always @*
    begin
        rdata_pins = 16'h0000;
        oe_lo_next = 1'b0;
        oe_hi_next = 1'b0;
        case (lane_reg)
            `LANE_WORD:
            begin
                rdata_pins = rd_data;                    // see (RQ12) (RQ13)
                oe_lo_next = 1'b1;
                oe_hi_next = 1'b1;
            end
            `LANE_EVEN_LO:
            begin
                rdata_pins = {8'h00, rd_data[7:0]};      // see (RQ14)
                oe_lo_next = 1'b1;
            end
            `LANE_ODD_LO:
            begin
                rdata_pins = {8'h00, rd_data[15:8]};     // see (RQ4)
                oe_lo_next = 1'b1;
            end
            `LANE_ODD_HI:
            begin
                rdata_pins = {rd_data[15:8], 8'h00};     // see (RQ2)
                oe_hi_next = 1'b1;
            end
            default:
            begin
                rdata_pins = 16'h0000;
                oe_lo_next = 1'b0;
                oe_hi_next = 1'b0;
            end
        endcase
    end

    // ==========================================
    // Access sequencer
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (wr_rise)
                    state_next = ST_WPEND;
                else if (rd_rise)
                    state_next = ST_RWAIT;
            end
            ST_WPEND:
            begin
                if (fifo_in_ready)
                    state_next = ST_IDLE;
            end
            ST_RWAIT:
            begin
                if (fifo_drained)
                    state_next = ST_RDATA;
            end
            ST_RDATA:
            begin
                if (rd_valid)
                    state_next = ST_DRIVE;
            end
            ST_DRIVE:
            begin
                if (~rd_act | ~selected)                 // see (RQ17)
                    state_next = ST_IDLE;
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    assign fifo_in_valid = (state_reg == ST_WPEND);

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg      <= ST_IDLE;
            rd_act_reg     <= 1'b0;
            wr_act_reg     <= 1'b0;
            lane_reg       <= `LANE_NONE;
            pend_reg       <= {`ENT_W{1'b0}};
            data_out       <= 16'h0000;
            data_oe_lo     <= 1'b0;
            data_oe_hi     <= 1'b0;
            wait_n         <= 1'b1;
            rd_req         <= 1'b0;
            rd_space       <= `SPACE_MEM;
            rd_addr        <= 11'h000;
            rd_be          <= `BE_NONE;
        end
        else
        begin
            state_reg  <= state_next;
            rd_act_reg <= rd_act;
            wr_act_reg <= wr_act;
            rd_req     <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (wr_rise)
                        pend_reg <= {space, acc_addr, be, wdata_norm};
                    else if (rd_rise)
                    begin
                        lane_reg <= lane;
                        rd_space <= space;
                        rd_addr  <= acc_addr;
                        rd_be    <= be;
                        wait_n   <= 1'b0;
                    end
                end
                ST_WPEND:
                    wait_n <= fifo_in_ready;
                ST_RWAIT:
                    rd_req <= fifo_drained;
                ST_RDATA:
                begin
                    if (rd_valid)
                    begin
                        data_out   <= rdata_pins;
                        data_oe_lo <= oe_lo_next;
                        data_oe_hi <= oe_hi_next;
                        wait_n     <= 1'b1;
                    end
                end
                ST_DRIVE:
                begin
                    if (~rd_act | ~selected)             // see (RQ17)
                    begin
                        data_oe_lo <= 1'b0;
                        data_oe_hi <= 1'b0;
                    end
                end
                default:
                begin
                    data_oe_lo <= 1'b0;
                    data_oe_hi <= 1'b0;
                    wait_n     <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================
    // Master and slave strap
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            strap_done_reg <= 1'b0;
            is_master      <= 1'b0;
            csel_pull_up   <= 1'b1;                      // see (RQ9)
        end
        else
        begin
            csel_pull_up <= 1'b1;
            if (~strap_done_reg)
            begin
                strap_done_reg <= 1'b1;
                // Low pin means master, open reads high as slave
                is_master <= (mode == `MODE_IDE) & ~csel_n; // see (RQ8) (RQ10) (RQ11)
            end
        end
    end

    // ==========================================
    // Write queue toward the core
    lane_fifo #(
        .WIDTH (`ENT_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (pend_reg),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (fifo_out),
        .drained   (fifo_drained)
    );

    assign wr_space = fifo_out[`ENT_SPACE_MSB:`ENT_SPACE_LSB];
    assign wr_addr  = fifo_out[`ENT_ADDR_MSB:`ENT_ADDR_LSB];
    assign wr_be    = fifo_out[`ENT_BE_MSB:`ENT_BE_LSB];
    assign wr_data  = fifo_out[`ENT_DATA_MSB:`ENT_DATA_LSB];
endmodule

// ### shared/card_bus_lane_select_consts.vh
// Constants for the card bus lane select front end
// Behaviour
// (RQ1) Card enables select card and byte/word width
// (RQ2) Second enable alone gives odd byte
// (RQ3) First enable steers by A0 and second enable
// (RQ4) Odd byte reachable on low lanes
// (RQ5) Disk mode chip select 0 picks task file
// (RQ6) Chip select 1 picks control and alt status
// (RQ7) Host negates selects during DMA, 16-bit only
// (RQ8) Cable select ignored in card modes
// (RQ9) Cable select sets role, pulled up
// (RQ10) Cable select grounded means master
// (RQ11) Cable select open means slave
// (RQ12) D00 is even byte least bit
// (RQ13) D08 is odd byte least bit
// (RQ14) Task file accesses are low lane bytes
// (RQ15) Disk data transfers are full words
// (RQ16) Only three low address bits decoded
// (RQ17) Unselected card ignores strobes, floats data
`ifndef CARD_BUS_LANE_SELECT_CONSTS_VH
`define CARD_BUS_LANE_SELECT_CONSTS_VH

// ==========================================
// Operating modes
`define MODE_MEM        2'h0
`define MODE_IO         2'h1
`define MODE_IDE        2'h2

// ==========================================
// Access spaces handed to the core
`define SPACE_MEM       3'h0
`define SPACE_IO        3'h1
`define SPACE_TASK      3'h2
`define SPACE_CTRL      3'h3
`define SPACE_DMA       3'h4

// ==========================================
// Lane codes
`define LANE_NONE       3'h0
`define LANE_WORD       3'h1
`define LANE_EVEN_LO    3'h2
`define LANE_ODD_LO     3'h3
`define LANE_ODD_HI     3'h4

// ==========================================
// Byte enables
`define BE_NONE         2'h0
`define BE_EVEN         2'h1
`define BE_ODD          2'h2
`define BE_WORD         2'h3

// ==========================================
// Write entry layout
`define ENT_W           32
`define ENT_DATA_LSB    0
`define ENT_DATA_MSB    15
`define ENT_BE_LSB      16
`define ENT_BE_MSB      17
`define ENT_ADDR_LSB    18
`define ENT_ADDR_MSB    28
`define ENT_SPACE_LSB   29
`define ENT_SPACE_MSB   31
`define FIFO_DEPTH      8
`define FIFO_AW         3
`define DATA_REG_ADDR   3'h0

`endif

// ### core/lane_fifo.v
// Write entry FIFO with registered output stage
`timescale 1ns/1ps
module lane_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
)(
    input  wire             clk,
    input  wire             reset,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output reg              out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             drained
);
    localparam [AW:0] DEPTH_C = DEPTH;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wptr_reg;
    reg [AW-1:0]    rptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    assign in_ready = (count_reg != DEPTH_C);
    assign push     = in_valid & in_ready;
    assign pop      = (count_reg != {(AW+1){1'b0}}) & (~out_valid | out_ready);
    assign drained  = (count_reg == {(AW+1){1'b0}}) & ~out_valid;

    // ==========================================
    // Storage
    always @(posedge clk)
    begin
        if (push)
            mem[wptr_reg] <= in_data;
    end

    // ==========================================
    // Pointers and output stage
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wptr_reg  <= {AW{1'b0}};
            rptr_reg  <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
                wptr_reg <= wptr_reg + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
            begin
                rptr_reg  <= rptr_reg + {{(AW-1){1'b0}}, 1'b1};
                out_data  <= mem[rptr_reg];
                out_valid <= 1'b1;
            end
            else if (out_ready)
                out_valid <= 1'b0;
            if (push & ~pop)
                count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
            else if (pop & ~push)
                count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
        end
    end
endmodule

// ### verification/card_bus_lane_select_chk.sv
// Assertion checker for the card bus lane select ports
`timescale 1ns/1ps
`include "card_bus_lane_select_consts.vh"
module card_bus_lane_select_chk (
    input wire        clk,
    input wire        reset,
    input wire [1:0]  mode,
    input wire        ce1_n,
    input wire        ce2_n,
    input wire [10:0] addr,
    input wire        dmack,
    input wire        csel_n,
    input wire        data_oe_lo,
    input wire        data_oe_hi,
    input wire        csel_pull_up,
    input wire        is_master,
    input wire        rd_req,
    input wire [2:0]  rd_space,
    input wire [10:0] rd_addr,
    input wire [1:0]  rd_be
);
    wire [2:0] a_lo  = addr[2:0];
    wire       strap = mode == 2'h2 && !csel_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================
    // Strap and pull-up
    property p_pull; csel_pull_up; endproperty
    a_pull: assert property (p_pull) else $error("pull-up off");
    property p_strap; $past(reset) && !reset |=> is_master == $past(strap); endproperty
    a_strap: assert property (p_strap) else $error("bad role");
    property p_card_role; $past(reset) && !reset && mode != 2'h2 |=> !is_master; endproperty
    a_card_role: assert property (p_card_role) else $error("role in card mode");
    property p_hold; !$past(reset, 2) && !$past(reset) |-> $stable(is_master); endproperty
    a_hold: assert property (p_hold) else $error("role moved");
    // ==========================================
    // Lane steering and disk register decode
    property p_unsel;
        (mode == 2'h3 || (mode != 2'h2 && ce1_n && ce2_n)) [*3] |-> !data_oe_lo && !data_oe_hi;
    endproperty
    a_unsel: assert property (p_unsel) else $error("drive while unselected");
    property p_hi_lane; data_oe_hi && $past(mode) != 2'h2 |-> !$past(ce2_n); endproperty
    a_hi_lane: assert property (p_hi_lane) else $error("high lanes without enable 2");
    property p_lo_lane; data_oe_lo && $past(mode) != 2'h2 |-> !$past(ce1_n); endproperty
    a_lo_lane: assert property (p_lo_lane) else $error("low lanes without enable 1");
    property p_disk_hi;
        data_oe_hi && $past(mode) == 2'h2 |-> ($past(dmack) && $past(ce1_n) && $past(ce2_n))
            || (!$past(dmack) && !$past(ce1_n) && $past(ce2_n) && $past(a_lo) == 3'h0);
    endproperty
    a_disk_hi: assert property (p_disk_hi) else $error("word drive on byte register");
    property p_cs0;
        rd_req && mode == 2'h2 && !dmack && !ce1_n && ce2_n
            |-> rd_space == `SPACE_TASK && rd_addr == {8'h0, a_lo};
    endproperty
    a_cs0: assert property (p_cs0) else $error("task file decode");
    property p_cs1;
        rd_req && mode == 2'h2 && !dmack && ce1_n && !ce2_n
            |-> rd_space == `SPACE_CTRL && rd_be == `BE_EVEN;
    endproperty
    a_cs1: assert property (p_cs1) else $error("control decode");
endmodule

bind card_bus_lane_select card_bus_lane_select_chk i_chk (
    .clk(clk), .reset(reset), .mode(mode), .ce1_n(ce1_n), .ce2_n(ce2_n), .addr(addr),
    .dmack(dmack), .csel_n(csel_n), .data_oe_lo(data_oe_lo), .data_oe_hi(data_oe_hi),
    .csel_pull_up(csel_pull_up), .is_master(is_master), .rd_req(rd_req),
    .rd_space(rd_space), .rd_addr(rd_addr), .rd_be(rd_be));

// ### verification/host_model.sv
// Host bus controller model driving the card pins
`timescale 1ns/1ps
module host_model (
    input  wire         clk,
    input  wire         wait_n,
    input  wire  [15:0] data_out,
    input  wire         data_oe_lo,
    input  wire         data_oe_hi,
    output logic [1:0]  mode,
    output logic        ce1_n,
    output logic        ce2_n,
    output logic [10:0] addr,
    output logic        oe_n,
    output logic        we_n,
    output logic        iord_n,
    output logic        iowr_n,
    output logic        dmack,
    output logic        csel_n,
    output logic [15:0] data_in
);
    initial
    begin
        mode = 2'h0;
        csel_n = 1'b0;
        {ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, dmack} = 7'h7e;
        addr = 11'h0;
        data_in = 16'h0;
    end
    // ==========================================
    // One strobed access, held until wait is released
    task automatic xfer(input logic w, c1, c2, dk, input logic [10:0] a,
                        input logic [15:0] d, output logic [15:0] q, output logic [1:0] oe);
        int n;
        begin
            @(negedge clk);
            {ce1_n, ce2_n, dmack, addr} = {c1, c2, dk, a};
            if (w)
                data_in = d;
            if (mode == 2'h0)
                {we_n, oe_n} = {~w, w};
            else
                {iowr_n, iord_n} = {~w, w};
            n = 0;
            repeat (3) @(negedge clk);
            while (!wait_n && n < 200)
            begin
                @(negedge clk);
                n++;
            end
            q = data_out;
            oe = {data_oe_hi, data_oe_lo};
            {ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, dmack} = 7'h7e;
            data_in = ~data_in;
        end
    endtask
endmodule

// ### verification/testbench.sv
// Self-checking testbench for the card bus lane select front end
`timescale 1ns/1ps
`include "card_bus_lane_select_consts.vh"
module testbench;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        wr_ready = 1'b0;
    logic        rd_valid = 1'b0;
    logic [15:0] rd_data = 16'h0;
    logic        stall = 1'b0;
    logic [15:0] rdw, rk;
    logic [32:0] x;
    logic [32:0] wq[$];
    int          n_fail = 0;
    int          tests_run = 0;
    int          k, m, n;
    wire  [1:0]  mode, wr_be, rd_be;
    wire         ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, dmack, csel_n, wait_n;
    wire         data_oe_lo, data_oe_hi, csel_pull_up, is_master, wr_valid, rd_req;
    wire  [10:0] addr, wr_addr, rd_addr;
    wire  [15:0] data_in, data_out, wr_data;
    wire  [2:0]  wr_space, rd_space;

    always #12.5 clk = ~clk;

    host_model i_host (.clk(clk), .wait_n(wait_n), .data_out(data_out),
        .data_oe_lo(data_oe_lo), .data_oe_hi(data_oe_hi), .mode(mode), .ce1_n(ce1_n),
        .ce2_n(ce2_n), .addr(addr), .oe_n(oe_n), .we_n(we_n), .iord_n(iord_n),
        .iowr_n(iowr_n), .dmack(dmack), .csel_n(csel_n), .data_in(data_in));
    card_bus_lane_select i_dut (.clk(clk), .reset(reset), .mode(mode), .ce1_n(ce1_n),
        .ce2_n(ce2_n), .addr(addr), .oe_n(oe_n), .we_n(we_n), .iord_n(iord_n),
        .iowr_n(iowr_n), .dmack(dmack), .csel_n(csel_n), .data_in(data_in),
        .data_out(data_out), .data_oe_lo(data_oe_lo), .data_oe_hi(data_oe_hi),
        .wait_n(wait_n), .csel_pull_up(csel_pull_up), .is_master(is_master),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_space(wr_space), .wr_addr(wr_addr),
        .wr_be(wr_be), .wr_data(wr_data), .rd_req(rd_req), .rd_space(rd_space),
        .rd_addr(rd_addr), .rd_be(rd_be), .rd_valid(rd_valid), .rd_data(rd_data));

    // ==========================================
    // Behavioural model
    function automatic logic [15:0] msk(input logic [1:0] be);
        msk = {{8{be[1]}}, {8{be[0]}}};
    endfunction
    function automatic logic [32:0] model(input logic [1:0] md, input logic c1, c2, dk,
                                          input logic [10:0] a, input logic [15:0] d);
        logic [32:0] e;
        begin
            e = {1'b1, md == 2'h1 ? `SPACE_IO : `SPACE_MEM, a, `BE_WORD, d};
            if (md == 2'h3 || (md != 2'h2 && c1 && c2))
                e[32] = 1'b0;
            else if (md != 2'h2 && c1)
                e[17:16] = `BE_ODD;
            else if (md != 2'h2 && c2)
                e[17:0] = a[0] ? {`BE_ODD, d[7:0], 8'h0} : {`BE_EVEN, d};
            else if (md == 2'h2 && dk)
                e = {c1 & c2, `SPACE_DMA, 11'h0, `BE_WORD, d};
            else if (md == 2'h2)
                e = {c1 ^ c2, c1 ? `SPACE_CTRL : `SPACE_TASK, 8'h0, a[2:0],
                     (c1 || a[2:0] != 3'h0) ? `BE_EVEN : `BE_WORD, d};
            model = e;
        end
    endfunction

    // ==========================================
    // Comparison, core responder and access tasks
    task automatic check(input logic [32:0] seen, exp);
        begin
            tests_run++;
            if (seen !== exp)
            begin
                n_fail++;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    always @(negedge clk)
    begin
        wr_ready = !stall && 1'($urandom);
        if (wr_valid && wr_ready)
        begin
            x = wq.size() != 0 ? wq.pop_front() : 33'h0;
            check({1'b1, wr_space, wr_addr, wr_be, wr_data & msk(wr_be)}, x);
        end
        if (rd_req)
        begin
            check({1'b1, rd_space, rd_addr, rd_be, 16'h0}, {1'b1, rk, 16'h0});
            check(33'(wq.size()), 33'h0);
        end
        rd_valid = rd_req;
        rd_data = rd_req ? rdw : ~rd_data;
    end
    task automatic op(input logic w, c1, c2, dk, input logic [10:0] a);
        logic [32:0] e;
        logic [15:0] d, q, qe;
        logic [1:0]  oe, oe_e;
        logic        odd;
        begin
            d = 16'($urandom);
            rdw = 16'($urandom);
            e = model(mode, c1, c2, dk, a, d);
            rk = e[31:16];
            if (w && e[32])
                wq.push_back({e[32:16], e[15:0] & msk(e[17:16])});
            i_host.xfer(w, c1, c2, dk, a, d, q, oe);
            check(33'(wait_n), 33'h1);
            odd = mode != 2'h2 && !c1 && c2 && a[0];
            oe_e = !e[32] ? 2'h0 : odd ? 2'h1 : e[17:16];
            qe = odd ? {8'h0, rdw[15:8]} : rdw;
            if (!w)
                check(33'({oe, q & msk(oe)}), 33'({oe_e, qe & msk(oe_e)}));
        end
    endtask
    task automatic rst(input logic [1:0] md, input logic cs);
        begin
            n = 0;
            while (wq.size() != 0 && n < 500)
            begin
                @(negedge clk);
                n++;
            end
            check(33'(wq.size()), 33'h0);
            if (tests_run != 1)
                repeat (4) @(negedge clk);
            i_host.mode = md;
            i_host.csel_n = cs;
            reset = 1'b1;
            repeat (2) @(negedge clk);
            reset = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask
    task automatic give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    // ==========================================
    // Test sequence
    initial
    begin
        n = $urandom(32'h9f308f4a);
        rst(2'h0, 1'b0);
        check(33'(is_master), 33'h0);
        check(33'(csel_pull_up), 33'h1);
        for (m = 0; m < 2; m++)
        begin
            i_host.mode = 2'(m);
            for (k = 0; k < 16; k++)
                op(k[0], k[1], k[2], 1'b0, {10'($urandom), k[3]});
        end
        $display("card modes done");
        rst(2'h2, 1'b1);
        check(33'(is_master), 33'h0);
        rst(2'h2, 1'b0);
        check(33'(is_master), 33'h1);
        for (k = 0; k < 16; k++)
            op(k[0], 1'b0, 1'b1, 1'b0, {8'($urandom), k[3:1]});
        for (k = 0; k < 16; k++)
            op(k[0], k[1], k[2], k[3], 11'($urandom));
        $display("disk mode done");
        i_host.mode = 2'h3;
        for (k = 0; k < 4; k++)
            op(k[0], 1'b0, k[1], 1'b0, 11'h0);
        $display("unselected done");
        i_host.mode = 2'h0;
        stall = 1'b1;
        for (k = 0; k < 9; k++)
            op(1'b1, 1'b0, 1'b0, 1'b0, 11'(k));
        fork
            op(1'b1, 1'b0, 1'b0, 1'b0, 11'h9);
            begin
                repeat (5) @(negedge clk);
                check(33'(wait_n), 33'h0);
                stall = 1'b0;
            end
        join
        op(1'b0, 1'b0, 1'b0, 1'b0, 11'h1);
        $display("fill done");
        rst(2'h0, 1'b0);
        give_verdict();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
endmodule
